//--- rx_ring_manager.sv
// Receive buffer ring manager: local DMA page allocation and overflow
`timescale 1ns/10ps
`include "rx_ring_params.svh"
module rx_ring_manager #(
	parameter int TALLY_W = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire rx_ring_pkg::page_t ring_first_page,
	input wire rx_ring_pkg::page_t ring_end_page,
	input wire rx_ring_pkg::page_t read_boundary_pointer,
	input wire logic wpp_load,
	input wire rx_ring_pkg::page_t wpp_value,
	input wire logic halt_bit,
	input wire logic accept_errors,
	input wire logic ovf_clear,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	input wire logic rx_bad,
	input wire logic rx_valid,
	output logic rx_ready,
	output logic [15:0] mem_addr_q,
	output logic [7:0] mem_data_q,
	output logic mem_we_q,
	input wire logic mem_ready,
	output rx_ring_pkg::page_t write_page_pointer_q,
	output logic ring_overflow_flag_q,
	output logic dma_off_q,
	output logic halted_q,
	output logic frame_done_q,
	output logic frame_reject_q,
	output logic frame_abort_q,
	output logic [TALLY_W-1:0] missed_tally_q
);
	import rx_ring_pkg::*;

	rx_state_t state_q;
	rx_state_t state_d;
	page_t page_q;
	page_t next_q;
	logic [7:0] off_q;
	logic [15:0] cnt_q;
	logic [1:0] hidx_q;
	logic [7:0] status_q;
	logic [9:0] buf_data;
	logic buf_valid;
	logic buf_ready;
	logic [7:0] b_data;
	logic b_last;
	logic b_bad;
	logic wr_free;
	logic take;
	page_t page_inc;
	page_t link_np;
	logic hit_bnd;
	logic at_end_off;
	logic start;
	logic refuse;
	logic link;
	logic abort;
	logic finish;
	logic reject;
	logic hdr_last;
	logic [7:0] hdr_byte;
	logic [7:0] status_d;
	logic data_wr;
	logic hdr_wr;
	logic halt_ok;

	rx_skid_buffer #(
		.WIDTH(10)
	) u_buf (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_data({rx_bad, rx_last, rx_data}),
		.in_valid(rx_valid),
		.in_ready(rx_ready),
		.out_data(buf_data),
		.out_valid(buf_valid),
		.out_ready(buf_ready)
	);

	assign b_data = buf_data[7:0];
	assign b_last = buf_data[8];
	assign b_bad = buf_data[9];

	// A write slot is free when the last write was accepted
	assign wr_free = !mem_we_q || mem_ready;

	// Next contiguous page, wrapping at ring end
	assign page_inc = page_q + 8'h01;
	assign link_np = (page_inc == ring_end_page) ? ring_first_page : page_inc;
	assign hit_bnd = link_np == read_boundary_pointer;
	assign at_end_off = off_q == `OFF_LAST;

	// A halted or disabled engine drains incoming bytes so the source never jams
	assign start = state_q == st_idle && buf_valid && !halt_bit && !dma_off_q;
	assign refuse = state_q == st_idle && buf_valid && (halt_bit || dma_off_q);
	assign buf_ready = (state_q == st_data && wr_free) || state_q == st_drop;
	assign take = buf_valid && buf_ready;

	assign data_wr = state_q == st_data && take;
	assign finish = data_wr && b_last;
	assign reject = finish && b_bad && !accept_errors;
	assign link = data_wr && !b_last && at_end_off && !hit_bnd;
	assign abort = data_wr && !b_last && at_end_off && hit_bnd;
	assign hdr_wr = state_q == st_hdr && wr_free;
	assign hdr_last = hdr_wr && hidx_q == `HDR_CNT_HI;
	assign halt_ok = halt_bit && state_q == st_idle;

	assign status_d = {6'h00, b_bad, !b_bad};

	// Header layout in the write page pointer page
	assign hdr_byte = (hidx_q == `HDR_STATUS) ? status_q :
		(hidx_q == `HDR_NEXT) ? next_q :
		(hidx_q == `HDR_CNT_LO) ? cnt_q[7:0] : cnt_q[15:8];

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			st_idle:
			begin
				if (start)
					state_d = st_data;
				else if (refuse)
					state_d = st_drop;
			end
			st_data:
			begin
				if (abort)
					state_d = st_drop;
				else if (finish)
					state_d = reject ? st_idle : st_hdr;
			end
			st_hdr:
			begin
				if (hdr_last)
					state_d = st_idle;
			end
			st_drop:
			begin
				if (take && b_last)
					state_d = st_idle;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			state_q <= st_idle;
		else
			state_q <= state_d;
	end

	// Page and offset of the local DMA
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			page_q <= `RST_PAGE;
			off_q <= 8'h00;
		end
		else if (start)
		begin
			page_q <= write_page_pointer_q;
			off_q <= `HDR_BYTES;
		end
		else if (link)
		begin
			page_q <= link_np;
			off_q <= 8'h00;
		end
		else if (reject || abort)
			page_q <= write_page_pointer_q;
		else if (data_wr)
			off_q <= off_q + 8'h01;
	end

	// Byte count, next packet page and status for the header
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cnt_q <= 16'h0000;
			next_q <= `RST_PAGE;
			status_q <= 8'h00;
			hidx_q <= 2'h0;
		end
		else
		begin
			if (start)
				cnt_q <= 16'h0000;
			else if (data_wr)
				cnt_q <= cnt_q + 16'h0001;
			if (finish)
			begin
				next_q <= link_np;
				status_q <= status_d;
			end
			if (finish)
				hidx_q <= 2'h0;
			else if (hdr_wr)
				hidx_q <= hidx_q + 2'h1;
		end
	end

	// Registered memory write port
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			mem_we_q <= 1'b0;
			mem_addr_q <= 16'h0000;
			mem_data_q <= 8'h00;
		end
		else if (data_wr)
		begin
			mem_we_q <= 1'b1;
			mem_addr_q <= {page_q, off_q};
			mem_data_q <= b_data;
		end
		else if (hdr_wr)
		begin
			mem_we_q <= 1'b1;
			mem_addr_q <= {write_page_pointer_q, 6'h00, hidx_q};
			mem_data_q <= hdr_byte;
		end
		else if (mem_ready)
			mem_we_q <= 1'b0;
	end

	// Host load of the write page pointer is honoured only between frames
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			write_page_pointer_q <= `RST_PAGE;
		else if (hdr_last)
			write_page_pointer_q <= next_q;
		else if (wpp_load && state_q == st_idle)
			write_page_pointer_q <= wpp_value;
	end

	// Overflow flag: a new overflow beats a clear in the same cycle
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			ring_overflow_flag_q <= 1'b0;
		else if (abort)
			ring_overflow_flag_q <= 1'b1;
		else if (ovf_clear)
			ring_overflow_flag_q <= 1'b0;
	end

	// Only the halt step of recovery turns local DMA back on
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			dma_off_q <= 1'b0;
		else if (abort)
			dma_off_q <= 1'b1;
		else if (halt_ok)
			dma_off_q <= 1'b0;
	end

	// Halt waits for the frame in progress to end
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			halted_q <= 1'b0;
		else
			halted_q <= halt_ok;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			frame_done_q <= 1'b0;
			frame_reject_q <= 1'b0;
			frame_abort_q <= 1'b0;
		end
		else
		begin
			frame_done_q <= hdr_last;
			frame_reject_q <= reject;
			frame_abort_q <= abort;
		end
	end

	// Tally saturates rather than wrapping
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			missed_tally_q <= '0;
		else if (refuse && !halt_bit && !(&missed_tally_q))
			missed_tally_q <= missed_tally_q + TALLY_W'(1);
	end

	wrap_link_a:
	assert property (@(posedge mclk) disable iff (!rst_n)
		link && page_inc == ring_end_page |=> page_q == ring_first_page && off_q == 8'h00)
	else $error("link did not wrap to ring first page");

	bnd_abort_a:
	assert property (@(posedge mclk) disable iff (!rst_n)
		data_wr && !b_last && at_end_off && link_np == read_boundary_pointer
		|=> state_q == st_drop && frame_abort_q && page_q == write_page_pointer_q)
	else $error("boundary reached without abort");

	no_overwrite_a:
	assert property (@(posedge mclk) disable iff (!rst_n)
		state_q == st_data && $stable(state_q) && $changed(page_q)
		|-> page_q != read_boundary_pointer)
	else $error("linked into the boundary page");

	ovf_sticky_a:
	assert property (@(posedge mclk) disable iff (!rst_n)
		frame_abort_q |-> ring_overflow_flag_q)
	else $error("overflow not flagged on abort");

	hdr_skip_a:
	assert property (@(posedge mclk) disable iff (!rst_n)
		start |=> off_q == 8'h04 && page_q == $past(write_page_pointer_q))
	else $error("frame did not start four bytes in");

	addr_form_a:
	assert property (@(posedge mclk) disable iff (!rst_n)
		data_wr |=> mem_we_q && mem_addr_q == {$past(page_q), $past(off_q)})
	else $error("buffer address not page over offset");

	reject_back_a:
	assert property (@(posedge mclk) disable iff (!rst_n)
		frame_reject_q |-> page_q == write_page_pointer_q && state_q == st_idle)
	else $error("rejected frame pages not reclaimed");

	hdr_done_a:
	assert property (@(posedge mclk) disable iff (!rst_n)
		// Bound allows a memory that takes a write only every other cycle
		finish && !reject |-> ##[1:12] frame_done_q)
	else $error("header not written in time");

	tally_halt_a:
	assert property (@(posedge mclk) disable iff (!rst_n)
		halt_bit |=> $stable(missed_tally_q))
	else $error("missed tally counted while halted");

	dma_stay_off_a:
	assert property (@(posedge mclk) disable iff (!rst_n)
		dma_off_q && !halt_bit && state_q == st_idle |=> state_q != st_data)
	else $error("reception restarted without recovery");
endmodule : rx_ring_manager

//--- rx_ring_params.svh
// Constants for the receive buffer ring manager
// Contract
// - Receive storage is a ring of whole 256-byte pages.
// - Two 8-bit page registers bound the ring inside 64k bytes.
// - Write page pointer holds the first page of the frame.
// - Reaching the read boundary page aborts the current reception.
// - Read boundary marks next packet to remove; host advances it.
// - Frame data starts four bytes into the write page pointer page.
// - Long frames link into the next contiguous page, never skipping.
// - A next page equal to ring end wraps to ring first page.
// - Link only when next page, after wrap at ring end, is not boundary.
// - Ring overflow aborts the incoming frame, stored frames survive.
// - Ring overflow sets the sticky overflow flag.
// - After overflow local DMA stays off until the halt sequence.
// - Halt finishes the frame in progress; host waits 1.6 ms.
// - Missed frame tally does not count while halted.
// - Good frame gets header at write page, pointer moves on.
// - Rejected bad frame reclaims its pages unless errors accepted.
`ifndef RX_RING_PARAMS_SVH
`define RX_RING_PARAMS_SVH
`define PAGE_W 8
`define OFF_W 8
`define OFF_LAST 8'hFF
`define HDR_BYTES 8'h04
`define HDR_STATUS 2'h0
`define HDR_NEXT 2'h1
`define HDR_CNT_LO 2'h2
`define HDR_CNT_HI 2'h3
`define ST_OK_BIT 0
`define ST_BAD_BIT 1
`define RST_PAGE 8'h00
`endif

//--- rx_ring_pkg.sv
// Types for the receive buffer ring manager
package rx_ring_pkg;
	typedef enum logic [1:0] {st_idle, st_data, st_hdr, st_drop} rx_state_t;
	typedef logic [7:0] page_t;
endpackage : rx_ring_pkg

//--- rx_skid_buffer.sv
// Two-entry buffer between the receive byte stream and the DMA writer
`timescale 1ns/10ps
module rx_skid_buffer #(
	parameter int WIDTH = 10
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	logic [WIDTH-1:0] mem_q [2];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	assign out_valid = cnt_q != 2'h0;
	assign out_data = mem_q[rd_ptr_q];

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			cnt_q <= 2'h0;
			in_ready <= 1'b0;
		end
		else
		begin
			wr_ptr_q <= wr_ptr_q ^ push;
			rd_ptr_q <= rd_ptr_q ^ pop;
			cnt_q <= cnt_d;
			// Registered ready: full is known one cycle ahead
			in_ready <= cnt_d != 2'h2;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (push)
			mem_q[wr_ptr_q] <= in_data;
	end
endmodule : rx_skid_buffer

//--- rx_mem_model.sv
// Behavioural byte memory standing at the local DMA port
`timescale 1ns/10ps
module rx_mem_model (
	input wire logic mclk,
	input wire logic slow,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_data,
	input wire logic mem_we,
	output logic mem_ready
);
	logic [7:0] mem [0:65535];
	logic phase_q = 1'b0;
	// Untouched cells read A5 so stray or missing writes show
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'hA5;
	end
	// Slow mode refuses every other cycle to back up the buffer
	assign mem_ready = !slow || phase_q;
	always @(posedge mclk)
	begin
		phase_q <= !phase_q;
		if (mem_we && mem_ready)
			mem[mem_addr] <= mem_data;
	end
endmodule : rx_mem_model

//--- rx_buffer_ring_manager_tb_top.sv
// Self-checking bench for the receive ring manager
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
	$display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end
module rx_buffer_ring_manager_tb_top;
	import rx_ring_pkg::*;
	logic mclk, rst_n, wpp_load, halt_bit, accept_errors, ovf_clear, slow;
	logic rx_last, rx_bad, rx_valid, rx_ready, mem_we_q, mem_ready;
	logic ring_overflow_flag_q, dma_off_q, halted_q;
	logic frame_done_q, frame_reject_q, frame_abort_q;
	page_t ring_first_page, ring_end_page, read_boundary_pointer, wpp_value;
	page_t write_page_pointer_q;
	logic [7:0] rx_data, mem_data_q, missed_tally_q;
	logic [15:0] mem_addr_q;
	int bad_count = 0;
	int check_count = 0;
	int n_done = 0;
	int n_rej = 0;
	int n_abt = 0;
	int d0, r0, a0;
	rx_ring_manager #(.TALLY_W(8)) i_dut (.mclk, .rst_n, .ring_first_page, .ring_end_page,
		.read_boundary_pointer, .wpp_load, .wpp_value, .halt_bit, .accept_errors,
		.ovf_clear, .rx_data, .rx_last, .rx_bad, .rx_valid, .rx_ready, .mem_addr_q,
		.mem_data_q, .mem_we_q, .mem_ready, .write_page_pointer_q, .ring_overflow_flag_q,
		.dma_off_q, .halted_q, .frame_done_q, .frame_reject_q, .frame_abort_q,
		.missed_tally_q);
	rx_mem_model i_mem (.mclk, .slow, .mem_addr(mem_addr_q), .mem_data(mem_data_q),
		.mem_we(mem_we_q), .mem_ready);
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Pulses are latched into counts so no frame end is missed
	always @(posedge mclk)
	begin
		if (frame_done_q === 1'b1) n_done <= n_done + 1;
		if (frame_reject_q === 1'b1) n_rej <= n_rej + 1;
		if (frame_abort_q === 1'b1) n_abt <= n_abt + 1;
	end
	task end_of_test();
		$display("Checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	task fail();
		bad_count++;
		$display("MISMATCH %0t wait ran out", $time);
		end_of_test();
	endtask : fail
	task snap();
		d0 = n_done;
		r0 = n_rej;
		a0 = n_abt;
	endtask : snap
	task automatic send(input int n, input logic bad, input logic [7:0] b);
		int i;
		int k;
		i = 0;
		k = 0;
		@(posedge mclk);
		rx_valid <= 1'b1;
		rx_data <= b;
		rx_last <= (n == 1);
		rx_bad <= bad && (n == 1);
		while (i < n && k < 4000)
		begin
			@(posedge mclk);
			k++;
			if (rx_ready === 1'b1)
			begin
				i++;
				rx_data <= b + 8'(i);
				rx_last <= (i == n - 1);
				rx_bad <= bad && (i == n - 1);
				rx_valid <= (i < n);
			end
		end
		if (k >= 4000)
			fail();
	endtask : send
	task automatic wait_ev();
		int k;
		k = 0;
		while (n_done + n_rej + n_abt == d0 + r0 + a0 && k < 3000)
		begin
			@(posedge mclk);
			k++;
		end
		if (k >= 3000)
			fail();
		repeat (3) @(posedge mclk);
		#1;
	endtask : wait_ev
	task set_wpp(input page_t p);
		@(posedge mclk);
		wpp_value <= p;
		wpp_load <= 1'b1;
		@(posedge mclk);
		wpp_load <= 1'b0;
	endtask : set_wpp
	task automatic hdr(input logic [15:0] a, input logic [7:0] s, nx, lo, hi);
		`CHK(i_mem.mem[a], s);
		`CHK(i_mem.mem[a + 16'h0001], nx);
		`CHK(i_mem.mem[a + 16'h0002], lo);
		`CHK(i_mem.mem[a + 16'h0003], hi);
	endtask : hdr
	task good_short();
		set_wpp(8'h40);
		snap();
		send(10, 1'b0, 8'h10);
		wait_ev();
		`CHK(n_done - d0, 1);
		`CHK(write_page_pointer_q, 8'h41);
		hdr(16'h4000, 8'h01, 8'h41, 8'h0A, 8'h00);
		`CHK(i_mem.mem[16'h4004], 8'h10);
		`CHK(i_mem.mem[16'h400D], 8'h19);
	endtask : good_short
	task long_wrap();
		@(posedge mclk);
		read_boundary_pointer <= 8'h42;
		slow <= 1'b1;
		set_wpp(8'h43);
		snap();
		send(300, 1'b0, 8'h00);
		wait_ev();
		@(posedge mclk);
		slow <= 1'b0;
		#1;
		hdr(16'h4300, 8'h01, 8'h41, 8'h2C, 8'h01);
		`CHK(i_mem.mem[16'h4304], 8'h00);
		`CHK(i_mem.mem[16'h43FF], 8'hFB);
		`CHK(i_mem.mem[16'h4000], 8'hFC);
		`CHK(i_mem.mem[16'h402F], 8'h2B);
		`CHK(write_page_pointer_q, 8'h41);
	endtask : long_wrap
	task reject_bad();
		snap();
		send(20, 1'b1, 8'h20);
		wait_ev();
		`CHK(n_rej - r0, 1);
		`CHK(write_page_pointer_q, 8'h41);
		`CHK(i_mem.mem[16'h4100], 8'hA5);
		@(posedge mclk);
		accept_errors <= 1'b1;
		snap();
		send(20, 1'b1, 8'h20);
		wait_ev();
		@(posedge mclk);
		accept_errors <= 1'b0;
		#1;
		hdr(16'h4100, 8'h02, 8'h42, 8'h14, 8'h00);
		`CHK(write_page_pointer_q, 8'h42);
	endtask : reject_bad
	task overflow();
		@(posedge mclk);
		read_boundary_pointer <= 8'h43;
		slow <= 1'b1;
		snap();
		send(300, 1'b0, 8'h00);
		wait_ev();
		@(posedge mclk);
		slow <= 1'b0;
		#1;
		`CHK(n_abt - a0, 1);
		`CHK(ring_overflow_flag_q, 1'b1);
		`CHK(dma_off_q, 1'b1);
		`CHK(write_page_pointer_q, 8'h42);
		`CHK(i_mem.mem[16'h4300], 8'h01);
		`CHK(i_mem.mem[16'h4304], 8'h00);
		snap();
		send(5, 1'b0, 8'h55);
		repeat (20) @(posedge mclk);
		#1;
		`CHK(missed_tally_q, 8'h01);
		`CHK(n_done - d0, 0);
		@(posedge mclk);
		// Count clearing, resend and loopback sit outside this block
		ovf_clear <= 1'b1;
		@(posedge mclk);
		ovf_clear <= 1'b0;
		@(posedge mclk);
		#1;
		`CHK(ring_overflow_flag_q, 1'b0);
		`CHK(dma_off_q, 1'b1);
	endtask : overflow
	task halt_resume();
		@(posedge mclk);
		halt_bit <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		`CHK(halted_q, 1'b1);
		`CHK(dma_off_q, 1'b0);
		send(5, 1'b0, 8'h33);
		repeat (20) @(posedge mclk);
		#1;
		`CHK(missed_tally_q, 8'h01);
		@(posedge mclk);
		halt_bit <= 1'b0;
		snap();
		send(5, 1'b0, 8'h60);
		wait_ev();
		`CHK(n_done - d0, 1);
		`CHK(write_page_pointer_q, 8'h43);
		// Halt raised mid-frame must still let the frame complete
		snap();
		fork
			send(40, 1'b0, 8'h70);
			begin
				repeat (8) @(posedge mclk);
				halt_bit <= 1'b1;
			end
		join
		wait_ev();
		`CHK(n_done - d0, 1);
		`CHK(write_page_pointer_q, 8'h40);
		`CHK(halted_q, 1'b1);
	endtask : halt_resume
	initial
	begin
		rst_n = 1'b0;
		{wpp_load, halt_bit, accept_errors, ovf_clear, slow} = 5'h00;
		{rx_last, rx_bad, rx_valid} = 3'h0;
		rx_data = 8'h00;
		wpp_value = 8'h00;
		ring_first_page = 8'h40;
		ring_end_page = 8'h44;
		read_boundary_pointer = 8'h40;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		`CHK(write_page_pointer_q, 8'h00);
		`CHK(ring_overflow_flag_q, 1'b0);
		`CHK(missed_tally_q, 8'h00);
		good_short();
		long_wrap();
		reject_bad();
		overflow();
		halt_resume();
		end_of_test();
	end
endmodule : rx_buffer_ring_manager_tb_top
